/* File: rtl/lcd_drv_pkg.sv */
package lcd_drv_pkg;
   localparam int SEG_COUNT = 33;
   localparam int FRAME_BITS = 36;
   localparam int SHIFT_LEN = SEG_COUNT + 1;
   localparam int BP_DIV = 16;
   localparam int BP_HALF = BP_DIV / 2;
   localparam int BP_CNT_W = 3;
   localparam int FIFO_DEPTH = 16;
   localparam int SYNC_STAGES = 2;
   localparam logic [SEG_COUNT-1:0] SEG_RESET = 33'h0_0000_0000;
endpackage

/* File: rtl/seg_fifo.sv */
`timescale 1ns/10ps
module seg_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,               // System clock.
   input wire logic i_rst,               // Synchronous reset, active high.
   input wire logic i_valid,             // Write request.
   output logic o_ready,                 // Room for a word.
   input wire logic [WIDTH-1:0] i_data,  // Write data.
   output logic o_valid,                 // A word is available.
   input wire logic i_ready,             // Reader takes the word.
   output logic [WIDTH-1:0] o_data       // Head word.
);
   localparam int AW = $clog2(DEPTH);
   // The pointers wrap by bit width, so only power-of-two depths keep full and empty exact.
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_param_chk
      $error("seg_fifo: DEPTH must be a power of two of at least 2 and WIDTH at least 1");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic wr, rd;

   always_comb begin
      o_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
      o_valid = wp_r != rp_r;
      wr = i_valid && o_ready;
      rd = o_valid && i_ready;
      wp_nxt = wp_r + (AW+1)'(wr);
      rp_nxt = rp_r + (AW+1)'(rd);
      o_data = mem[rp_r[AW-1:0]];
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
      if (wr) begin
         mem[wp_r[AW-1:0]] <= i_data;
      end
   end
endmodule

/* File: rtl/lcd_seg_driver.sv */
`timescale 1ns/10ps
// Summary of operation
// RL1 - Frames arrive on two lines only: serial data and serial clock, no load strobe.
// RL2 - Host sends start bit one, then 33 segment bits, then two ignored bits.
// RL3 - Host gives two more clocks after the 34 defined bits, 36 in all.
// RL4 - Rising edge of clock 36 copies the 33 shifted bits toward the latches.
// RL5 - Falling edge of clock 36 clears every shift stage but the first master for the next frame.
// RL6 - Clear spares the first stage's master, so back-to-back frames keep their start bit.
// RL7 - Host should drive zero data during clocks 35 and 36.
// RL8 - Latches hold their values until a whole new frame arrives.
// RL9 - Between backplane edges, only segments whose latched bit changed toggle; others stay steady.
// RL10 - Each segment bit drives one fixed segment output, all independent.
// RL11 - Host does all character encoding; the driver has none.
// RL12 - Backplane output is the oscillator divided by sixteen.
// RL13 - External backplane input must have exactly fifty percent duty.
// RL14 - Data is sampled on each rising serial clock edge into stage one.
// RL15 - Start bit reaching the end of the shift path marks clock 36.
// RL16 - Latched one drives opposite to backplane; latched zero in phase.
module lcd_seg_driver
   import lcd_drv_pkg::*;
(
   input wire logic i_clk,                        // System clock, 125 MHz.
   input wire logic i_rst,                        // Synchronous reset, active high.
   input wire logic i_ser_data,                   // Serial data pin, asynchronous.
   input wire logic i_ser_clk,                    // Serial clock pin, asynchronous.
   input wire logic i_rc_oscillator_pin,          // Oscillator pin, asynchronous.
   input wire logic i_backplane_drive_in,         // External backplane pin, asynchronous.
   input wire logic i_bp_ext_sel,                 // High selects the external backplane.
   output logic o_backplane_drive_out,            // Backplane output: divided oscillator, or the external pin when selected.
   output logic [SEG_COUNT-1:0] o_seg,            // Segment drive pins.
   output logic [SEG_COUNT-1:0] o_seg_latched,    // Latched segment states.
   output logic o_frame_done                      // One-cycle pulse per received frame.
);
   // The chain length, frame length and divider width depend on each other; refuse a mismatch.
   if (FRAME_BITS != SHIFT_LEN + 2 || SEG_COUNT < 1) begin : g_frame_chk
      $error("lcd_seg_driver: FRAME_BITS must equal SEG_COUNT plus three");
   end
   if ((1 << BP_CNT_W) < BP_HALF || BP_HALF < 1 || SYNC_STAGES != 2) begin : g_bp_chk
      $error("lcd_seg_driver: backplane counter too narrow or synchroniser depth unsupported");
   end

   // Pins cross into i_clk through two flops; only the second flop is read.
   // The backplane select is a pin as well, so it is synchronised with the rest.
   logic [4:0] s1_r, s1_nxt, s2_r, s2_nxt;
   logic sclk_d_r, sclk_d_nxt, osc_d_r, osc_d_nxt;
   logic sdat, sclk, osc, bpin, bpsel;

   always_comb begin
      s1_nxt = {i_bp_ext_sel, i_backplane_drive_in, i_rc_oscillator_pin, i_ser_clk, i_ser_data};
      s2_nxt = s1_r;
      {bpsel, bpin, osc, sclk, sdat} = s2_r;
      sclk_d_nxt = sclk;
      osc_d_nxt = osc;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_r <= 5'h00;
         s2_r <= 5'h00;
         sclk_d_r <= 1'b0;
         osc_d_r <= 1'b0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         sclk_d_r <= sclk_d_nxt;
         osc_d_r <= osc_d_nxt;
      end
   end

   logic sclk_rise, sclk_fall, osc_rise;
   assign sclk_rise = sclk && !sclk_d_r;
   assign sclk_fall = !sclk && sclk_d_r;
   assign osc_rise = osc && !osc_d_r;

   // Shift path: master captures on the rising edge, slaves follow on the falling
   // edge, as a static master-slave chain would. Stage 0 of the slave chain is the
   // first stage slave; the start bit lands in stage SHIFT_LEN+2 on clock 36.
   localparam int CHAIN = FRAME_BITS - 1;
   logic master0_r, master0_nxt;                  // First stage master, never cleared.
   logic [CHAIN-1:0] master_r, master_nxt;        // Masters of stages 2..36.
   logic [CHAIN:0] slave_r, slave_nxt;            // Slaves of stages 1..36.
   logic load_pend_r, load_pend_nxt;
   logic [SEG_COUNT-1:0] capture_r, capture_nxt;
   logic push;

   always_comb begin
      master0_nxt = master0_r;
      master_nxt = master_r;
      slave_nxt = slave_r;
      load_pend_nxt = load_pend_r;
      capture_nxt = capture_r;
      push = 1'b0;
      if (sclk_rise) begin
         master0_nxt = sdat;                                           // [RL14] [RL1]
         master_nxt = slave_r[CHAIN-1:0];
         // Start bit at the stage 35 slave means this is clock 36.
         if (slave_r[CHAIN-1]) begin                                   // [RL15]
            capture_nxt = slave_r[CHAIN-2 -: SEG_COUNT];               // [RL4] [RL10]
            push = 1'b1;                                               // [RL4]
            load_pend_nxt = 1'b1;
         end
      end
      if (sclk_fall) begin
         slave_nxt = {master_r, master0_r};
         // The clear waits for the falling edge so the capture on the rising edge comes first.
         if (load_pend_r) begin
            // Clear every stage but the first master so a start bit just taken survives.
            // A tail bit of one left there is harmless: the next rising edge overwrites it
            // before any slave can copy it.
            master_nxt = '0;                                           // [RL5] [RL6]
            slave_nxt = '0;                                            // [RL5]
            load_pend_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         master0_r <= 1'b0;
         master_r <= '0;
         slave_r <= '0;
         load_pend_r <= 1'b0;
         capture_r <= SEG_RESET;
      end else begin
         master0_r <= master0_nxt;
         master_r <= master_nxt;
         slave_r <= slave_nxt;
         load_pend_r <= load_pend_nxt;
         capture_r <= capture_nxt;
      end
   end

   // Frames queue here on the way to o_seg_latched, which takes each one a cycle later; the
   // latch side always drains, so the queue only fills if draining is held off.
   logic fifo_valid, fifo_ready_in;
   logic [SEG_COUNT-1:0] fifo_data;
   logic push_r, push_nxt;
   // The push is registered so that it meets capture_r in the same cycle; the extra
   // cycle of latency is of no consequence next to a serial bit time.
   assign push_nxt = push;

   seg_fifo #(
      .WIDTH(SEG_COUNT),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_valid(push_r),
      .o_ready(fifo_ready_in),
      .i_data(capture_r),
      .o_valid(fifo_valid),
      .i_ready(1'b1),
      .o_data(fifo_data)
   );

   logic [SEG_COUNT-1:0] latch_r, latch_nxt;
   logic done_r, done_nxt;

   always_comb begin
      latch_nxt = latch_r;                                             // [RL8]
      done_nxt = 1'b0;
      if (fifo_valid) begin
         latch_nxt = fifo_data;                                        // [RL8]
         done_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         push_r <= 1'b0;
         latch_r <= SEG_RESET;
         done_r <= 1'b0;
      end else begin
         push_r <= push_nxt && fifo_ready_in;
         latch_r <= latch_nxt;
         done_r <= done_nxt;
      end
   end

   // Backplane: internal divide by sixteen, or the external pin.
   logic [BP_CNT_W-1:0] osc_cnt_r, osc_cnt_nxt;
   logic bp_int_r, bp_int_nxt;
   logic bp_r, bp_nxt;
   logic [SEG_COUNT-1:0] seg_r, seg_nxt;

   always_comb begin
      osc_cnt_nxt = osc_cnt_r;
      bp_int_nxt = bp_int_r;
      if (osc_rise) begin
         // Toggling every eight oscillator edges gives one period per sixteen.
         osc_cnt_nxt = osc_cnt_r + BP_CNT_W'(1);                       // [RL12]
         if (osc_cnt_r == BP_CNT_W'(BP_HALF - 1)) begin
            osc_cnt_nxt = '0;
            bp_int_nxt = !bp_int_r;                                    // [RL12]
         end
      end
      bp_nxt = bpsel ? bpin : bp_int_r;                                // [RL13]
      // Each segment is registered from a stable latch, so unchanged bits never glitch.
      // The segments follow the backplane output one cycle late, a skew of a few
      // nanoseconds that the display never sees as a DC offset.
      seg_nxt = latch_r ^ {SEG_COUNT{bp_r}};                           // [RL16] [RL9]
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         osc_cnt_r <= '0;
         bp_int_r <= 1'b0;
         bp_r <= 1'b0;
         seg_r <= SEG_RESET;
      end else begin
         osc_cnt_r <= osc_cnt_nxt;
         bp_int_r <= bp_int_nxt;
         bp_r <= bp_nxt;
         seg_r <= seg_nxt;
      end
   end

   assign o_backplane_drive_out = bp_r;
   assign o_seg = seg_r;
   assign o_seg_latched = latch_r;
   assign o_frame_done = done_r;
endmodule

/* File: verification/lcd_host_model.sv */
`timescale 1ns/10ps
module lcd_host_model (
   input wire logic i_clk,  // Pacing clock.
   output logic o_ser_clk,  // Serial clock.
   output logic o_ser_data  // Serial data.
);
   initial begin
      o_ser_clk = 1'b0;
      o_ser_data = 1'b0;
   end
   // The clock stands low between frames; four cycles high and four low give 64 ns.
   task automatic send(input logic [32:0] segs, input logic [1:0] tail);
      logic [35:0] f;
      f = {1'b1, segs, tail};
      @(negedge i_clk);
      for (int i = 35; i >= 0; i--) begin
         o_ser_data = f[i];
         repeat (4) @(negedge i_clk);
         o_ser_clk = 1'b1;
         repeat (4) @(negedge i_clk);
         o_ser_clk = 1'b0;
      end
      // An idle line shows the inverse of its last bit, so a stale value never passes.
      o_ser_data = ~f[0];
   endtask
endmodule

/* File: verification/lcd_seg_driver_monitor.sv */
`timescale 1ns/10ps
module lcd_seg_driver_monitor
   import lcd_drv_pkg::*;
(
   input wire logic i_clk,                      // Clock.
   input wire logic i_rst,                      // Reset.
   input wire logic i_ser_clk,                  // Serial clock.
   input wire logic i_rc_oscillator_pin,        // Oscillator.
   input wire logic i_backplane_drive_in,       // External backplane.
   input wire logic i_bp_ext_sel,               // Backplane select.
   input wire logic o_backplane_drive_out,      // Backplane out.
   input wire logic [SEG_COUNT-1:0] o_seg,      // Segments.
   input wire logic [SEG_COUNT-1:0] o_seg_latched, // Latches.
   input wire logic o_frame_done                // Frame pulse.
);
   logic osc_q, bp_q;
   logic [4:0] rises;
   logic [3:0] since_hi;
   always_ff @(posedge i_clk) begin
      osc_q <= i_rc_oscillator_pin;
      bp_q <= o_backplane_drive_out;
      if (i_rst || i_bp_ext_sel || bp_q != o_backplane_drive_out) rises <= 5'h00;
      else if (i_rc_oscillator_pin && !osc_q) rises <= rises + 5'h01;
      if (i_ser_clk) since_hi <= 4'h0;
      else if (since_hi != 4'hF) since_hi <= since_hi + 4'h1;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   reset_clear_a: assert property ($past(i_rst) |-> o_seg_latched == SEG_RESET && !o_frame_done)
      else $error("outputs not clear after reset");
   latched_hold_a: assert property ($changed(o_seg_latched) |-> o_frame_done)
      else $error("latches moved without a frame");
   done_pulse_a: assert property (o_frame_done |=> !o_frame_done)
      else $error("frame pulse longer than one cycle");
   done_clocked_a: assert property (o_frame_done |-> since_hi <= 4'h8)
      else $error("frame pulse far from a serial clock");
   seg_phase_a: assert property (($stable(o_seg_latched) && $stable(o_backplane_drive_out)) [*2]
      |-> o_seg == (o_seg_latched ^ {SEG_COUNT{o_backplane_drive_out}}))
      else $error("segment phase wrong");
   seg_steady_a: assert property ($stable(o_backplane_drive_out) [*3]
      |-> (o_seg ^ $past(o_seg)) == ($past(o_seg_latched) ^ $past(o_seg_latched, 2)))
      else $error("segment moved without a latch change");
   bp_divide_a: assert property ($changed(o_backplane_drive_out) && !i_bp_ext_sel |-> rises == BP_HALF)
      else $error("backplane divide wrong");
   bp_extern_a: assert property ((i_bp_ext_sel && $stable(i_backplane_drive_in)) [*6]
      |-> o_backplane_drive_out == i_backplane_drive_in)
      else $error("external backplane not passed");
   frame_c: cover property (o_frame_done);
   bp_c: cover property ($changed(o_backplane_drive_out) && !i_bp_ext_sel);
   ext_c: cover property (i_bp_ext_sel && $changed(o_backplane_drive_out));
endmodule
bind lcd_seg_driver lcd_seg_driver_monitor u_lcd_seg_driver_monitor (.i_clk, .i_rst, .i_ser_clk,
   .i_rc_oscillator_pin, .i_backplane_drive_in, .i_bp_ext_sel, .o_backplane_drive_out, .o_seg,
   .o_seg_latched, .o_frame_done);

/* File: verification/lcd_seg_driver_tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
   $display("wrong value at %0t: %h %h", $time, a, b); end end
module lcd_seg_driver_tb;
   import lcd_drv_pkg::*;
   logic i_clk, i_rst, ser_clk, ser_data, osc, backplane_drive_in, sel, bp, done;
   logic [SEG_COUNT-1:0] seg, lat;
   int errors = 0, n_checks = 0, n_done = 0;
   lcd_host_model u_lcd_host_model (.i_clk(i_clk), .o_ser_clk(ser_clk), .o_ser_data(ser_data));
   lcd_seg_driver u_lcd_seg_driver (.i_clk(i_clk), .i_rst(i_rst), .i_ser_data(ser_data), .i_ser_clk(ser_clk),
      .i_rc_oscillator_pin(osc), .i_backplane_drive_in(backplane_drive_in), .i_bp_ext_sel(sel),
      .o_backplane_drive_out(bp), .o_seg(seg), .o_seg_latched(lat), .o_frame_done(done));
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // The oscillator stays low through reset so no false edge meets the synchronisers.
   initial begin
      osc = 1'b0;
      repeat (4) @(negedge i_clk);
      forever begin
         repeat (5) @(negedge i_clk);
         osc = ~osc;
      end
   end
   always @(posedge i_clk) if (done === 1'b1) n_done++;
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wait_n(input int want);
      int k;
      for (k = 0; k < 400 && n_done < want; k++) @(negedge i_clk);
      if (k == 400) begin
         errors++;
         conclude();
      end
   endtask
   task automatic frame(input logic [32:0] s, input logic [1:0] tail);
      int want;
      logic b;
      want = n_done + 1;
      u_lcd_host_model.send(s, tail);
      wait_n(want);
      `CHK(lat, s)
      `CHK(n_done, want)
      // The segments register the backplane seen one edge earlier.
      b = bp;
      @(negedge i_clk);
      `CHK(seg, s ^ {SEG_COUNT{b}})
   endtask
   task automatic back_to_back();
      int want;
      want = n_done + 2;
      u_lcd_host_model.send(33'h0_F0F0_F0F0, 2'b00);
      u_lcd_host_model.send(33'h1_0F0F_0F0F, 2'b00);
      wait_n(want);
      `CHK(lat, 33'h1_0F0F_0F0F)
      `CHK(n_done, want)
   endtask
   task automatic hold_idle();
      int was;
      was = n_done;
      repeat (300) @(negedge i_clk);
      `CHK(lat, 33'h1_0F0F_0F0F)
      `CHK(n_done, was)
   endtask
   task automatic bp_internal();
      logic was;
      int k, n;
      was = bp;
      for (k = 0; k < 200 && bp === was; k++) @(negedge i_clk);
      was = bp;
      for (n = 0; n < 200 && bp === was; n++) @(negedge i_clk);
      if (k == 200 || n == 200) begin
         errors++;
         conclude();
      end
      `CHK(n, BP_HALF * 10)
   endtask
   task automatic bp_external();
      sel = 1'b1;
      for (int i = 0; i < 4; i++) begin
         backplane_drive_in = ~backplane_drive_in;
         repeat (20) @(negedge i_clk);
         `CHK(bp, backplane_drive_in)
         `CHK(seg, 33'h1_0F0F_0F0F ^ {SEG_COUNT{backplane_drive_in}})
      end
   endtask
   initial begin
      i_rst = 1'b1;
      backplane_drive_in = 1'b0;
      sel = 1'b0;
      repeat (3) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (3) @(negedge i_clk);
      `CHK(lat, SEG_RESET)
      frame(33'h1_2345_6789, 2'b00);
      for (int i = 0; i < SEG_COUNT; i++) frame(33'h0_0000_0001 << i, 2'b00);
      frame(33'h1_FFFF_FFFF, 2'b11);
      frame(33'h0_0000_0000, 2'b00);
      back_to_back();
      hold_idle();
      bp_internal();
      bp_external();
      conclude();
   end
endmodule
